// ==== lsp_top.v ====
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "lsp_regs.vh"
module lsp_top #(
  parameter [15:0] SYNC_MIN_CYC = `LSP_SYNC_MIN_CYC,
  parameter [15:0] SYNC_MAX_CYC = `LSP_SYNC_MAX_CYC,
  parameter [15:0] BREAK_MIN_CYC = `LSP_BREAK_MIN_CYC
) (
  input wire mclk,
  input wire arst_n,
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire linRx,
  output reg linTx,
  output reg syncIrq,
  output reg idIrq,
  output reg rxIrq,
  output reg txIrq
);
  localparam [2:0] S_BRK = 3'd0;
  localparam [2:0] S_SYNC = 3'd1;
  localparam [2:0] S_PID = 3'd2;
  localparam [2:0] S_DIR = 3'd3;
  localparam [2:0] S_RX = 3'd4;
  localparam [2:0] S_TX = 3'd5;
  localparam [15:0] STOP15 = `LSP_STOP_MIN15_CYC;
  localparam [15:0] STOP30 = `LSP_STOP_MIN30_CYC;

  function [7:0] lspAddc;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      lspAddc = s[7:0] + {7'h00, s[8]};
    end
  endfunction

  // ==========================================
  // state
  reg [6:0] cfg_q;
  reg dir_q;
  reg [3:0] cnt_q;
  reg [6:0] stat_q;
  reg [7:0] pid_q;
  reg [63:0] rxBuf_q;
  reg [63:0] txBuf_q;
  reg [15:0] bitTime_q;
  reg [2:0] state_q;
  reg [3:0] idx_q;
  reg [7:0] sum_q;
  reg [15:0] lowRun_q;
  reg [15:0] highRun_q;
  reg prevLine_q;
  reg delimArm_q;
  reg stopArm_q;
  reg [15:0] syncCnt_q;
  reg [2:0] edges_q;
  reg [11:0] txSh_q;
  reg [3:0] txBits_q;
  reg [15:0] txTmr_q;
  reg [7:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;

  wire raw = cfg_q[`LSP_CFG_RAW];
  wire [15:0] stopMin = cfg_q[`LSP_CFG_TOL] ? STOP30 : STOP15;
  wire fall = prevLine_q & ~linRx;
  wire rise = ~prevLine_q & linRx;
  wire rxEn = !raw && (state_q == S_PID || state_q == S_RX || state_q == S_TX);
  wire rxDone;
  wire [7:0] rxData;
  wire rxStopBad;
  wire [7:0] p = rxData;
  wire idParOk = (p[6] == (p[0] ^ p[1] ^ p[2] ^ p[4])) &&
                 (p[7] == ~(p[1] ^ p[3] ^ p[4] ^ p[5]));
  wire syncEnd = state_q == S_SYNC && fall && edges_q == 3'd4;
  wire rxLast = idx_q >= cnt_q;
  wire doWrite = !awready && !wready && !bvalid;
  wire wipeNow = doWrite && awAddr_q == `LSP_OFS_CFG && wStrb_q[0] &&
                 wData_q[`LSP_CFG_WIPE];
  wire breakSeen = !raw && rise && lowRun_q >= BREAK_MIN_CYC;
  reg [6:0] statSet;
  reg [31:0] rdMux;
  reg rdOk;

  lsp_rx_byte rxByte (
    .mclk(mclk),
    .arst_n(arst_n),
    .enable(rxEn),
    .lineIn(linRx),
    .bitTime(bitTime_q),
    .done_q(rxDone),
    .data_q(rxData),
    .stopBad_q(rxStopBad)
  );

  // ==========================================
  // error detection
  always @* begin
    statSet = 7'h00;
    statSet[`LSP_ST_CSUM] = state_q == S_RX && rxDone && rxLast &&
                            rxData != ~sum_q;
    statSet[`LSP_ST_PAR] = state_q == S_PID && rxDone && !idParOk;
    statSet[`LSP_ST_STOPLVL] = rxEn && rxDone && rxStopBad;
    statSet[`LSP_ST_STOPSHORT] = fall && stopArm_q && highRun_q < stopMin;
    statSet[`LSP_ST_SYNCSHORT] = syncEnd && syncCnt_q < SYNC_MIN_CYC;
    statSet[`LSP_ST_SYNCLONG] = syncEnd && syncCnt_q > SYNC_MAX_CYC;
    statSet[`LSP_ST_DELIM] = state_q == S_SYNC && fall && delimArm_q &&
                             highRun_q < stopMin;
    if (raw)
      statSet = 7'h00;
  end

  // ==========================================
  // read decode
  always @* begin
    rdMux = 32'h0000_0000;
    rdOk = 1'b1;
    case (araddr)
      `LSP_OFS_CFG: rdMux = {25'h0000000, cfg_q};
      `LSP_OFS_CTRL: rdMux = {31'h00000000, dir_q};
      `LSP_OFS_CNT: rdMux = {28'h0000000, cnt_q};
      `LSP_OFS_STAT: rdMux = {25'h0000000, stat_q};
      `LSP_OFS_PID: rdMux = {24'h000000, pid_q};
      `LSP_OFS_STATE: rdMux = {29'h00000000, state_q};
      `LSP_OFS_RXLO: rdMux = rxBuf_q[31:0];
      `LSP_OFS_RXHI: rdMux = rxBuf_q[63:32];
      `LSP_OFS_TXLO: rdMux = txBuf_q[31:0];
      `LSP_OFS_TXHI: rdMux = txBuf_q[63:32];
      `LSP_OFS_BITT: rdMux = {16'h0000, bitTime_q};
      default: rdOk = 1'b0;
    endcase
  end

  // ==========================================
  // bus slave, registers and frame engine
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `LSP_RESP_OK;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= `LSP_RESP_OK;
      rdata <= 32'h0000_0000;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      cfg_q <= `LSP_CFG_RST;
      dir_q <= 1'b0;
      cnt_q <= 4'h0;
      stat_q <= 7'h00;
      pid_q <= 8'h00;
      rxBuf_q <= 64'h0;
      txBuf_q <= 64'h0;
      bitTime_q <= `LSP_BITT_RST;
      state_q <= S_BRK;
      idx_q <= 4'h0;
      sum_q <= 8'h00;
      lowRun_q <= 16'h0000;
      highRun_q <= 16'h0000;
      prevLine_q <= 1'b1;
      delimArm_q <= 1'b0;
      stopArm_q <= 1'b0;
      syncCnt_q <= 16'h0000;
      edges_q <= 3'd0;
      txSh_q <= 12'hfff;
      txBits_q <= 4'h0;
      txTmr_q <= 16'h0000;
      linTx <= 1'b1;
      syncIrq <= 1'b0;
      idIrq <= 1'b0;
      rxIrq <= 1'b0;
      txIrq <= 1'b0;
    end else begin
      syncIrq <= 1'b0;
      idIrq <= 1'b0;
      rxIrq <= 1'b0;
      txIrq <= 1'b0;
      prevLine_q <= linRx;
      lowRun_q <= linRx ? 16'h0000 : (&lowRun_q ? lowRun_q : lowRun_q + 16'h0001);
      highRun_q <= !linRx ? 16'h0000 : (&highRun_q ? highRun_q : highRun_q + 16'h0001);
      // set wins over the wipe in the same cycle
      stat_q <= (wipeNow ? 7'h00 : stat_q) | statSet;
      if (rxEn && rxDone)
        stopArm_q <= 1'b1;
      else if (fall)
        stopArm_q <= 1'b0;

      // write channel handshakes, either order
      if (awvalid && awready) begin
        awready <= 1'b0;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= `LSP_RESP_OK;
        case (awAddr_q)
          `LSP_OFS_CFG: if (wStrb_q[0])
            cfg_q <= {wData_q[6], 1'b0, wData_q[4:0]};
          `LSP_OFS_CTRL: if (wStrb_q[0])
            dir_q <= wData_q[`LSP_CTRL_DIR];
          `LSP_OFS_CNT: if (wStrb_q[0])
            cnt_q <= wData_q[3:0] > `LSP_CNT_MAX ? `LSP_CNT_MAX : wData_q[3:0];
          `LSP_OFS_TXLO, `LSP_OFS_TXHI: begin : txw
            integer b;
            for (b = 0; b < 4; b = b + 1) begin
              if (wStrb_q[b]) begin
                if (awAddr_q == `LSP_OFS_TXLO)
                  txBuf_q[b*8 +: 8] <= wData_q[b*8 +: 8];
                else
                  txBuf_q[32 + b*8 +: 8] <= wData_q[b*8 +: 8];
              end
            end
          end
          `LSP_OFS_STAT, `LSP_OFS_PID, `LSP_OFS_STATE, `LSP_OFS_RXLO,
          `LSP_OFS_RXHI, `LSP_OFS_BITT: bresp <= `LSP_RESP_OK;
          default: bresp <= `LSP_RESP_ERR;
        endcase
      end

      // read channel
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rdMux;
        rresp <= rdOk ? `LSP_RESP_OK : `LSP_RESP_ERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end

      // transmit bit timer, runs while txBits_q is nonzero, also after raw forces S_BRK
      if (txBits_q != 4'h0) begin
        if (txTmr_q == 16'h0000) begin
          txTmr_q <= bitTime_q - 16'h0001;
          txBits_q <= txBits_q - 4'h1;
          linTx <= (txBits_q == 4'h1) ? 1'b1 : txSh_q[0];
          txSh_q <= {1'b1, txSh_q[11:1]};
        end else begin
          txTmr_q <= txTmr_q - 16'h0001;
        end
      end

      case (state_q)
        S_BRK: begin
          edges_q <= 3'd0;
        end
        S_SYNC: begin
          if (edges_q != 3'd0)
            syncCnt_q <= syncCnt_q + 16'h0001;
          if (fall) begin
            delimArm_q <= 1'b0;
            edges_q <= edges_q + 3'd1;
            // count from one so the span holds whole cycles
            if (edges_q == 3'd0)
              syncCnt_q <= 16'h0001;
          end
          if (syncEnd) begin
            bitTime_q <= {3'b000, syncCnt_q[15:3]};
            syncIrq <= 1'b1;
            state_q <= S_PID;
          end
        end
        S_PID: begin
          if (rxDone) begin
            if (!idParOk) begin
              state_q <= S_BRK;
            end else begin
              // identifier is stored raw, never decoded here
              pid_q <= rxData;
              idIrq <= 1'b1;
              state_q <= cfg_q[`LSP_CFG_SKIP] ? S_BRK : S_DIR;
            end
          end
        end
        S_DIR: begin
          // software picks direction after the identifier interrupt
          if (doWrite && awAddr_q == `LSP_OFS_CTRL && wStrb_q[0]) begin
            idx_q <= 4'h0;
            sum_q <= cfg_q[`LSP_CFG_CSM] ? pid_q : 8'h00;
            state_q <= wData_q[`LSP_CTRL_DIR] ? S_TX : S_RX;
          end
        end
        S_RX: begin
          if (rxDone) begin
            if (!rxLast) begin
              rxBuf_q[{idx_q[2:0], 3'b000} +: 8] <= rxData;
              sum_q <= lspAddc(sum_q, rxData);
              idx_q <= idx_q + 4'h1;
            end else begin
              if (rxData == ~sum_q) begin
                rxIrq <= 1'b1;
                pid_q <= 8'h00;
              end
              state_q <= S_BRK;
            end
          end
        end
        S_TX: begin
          if (txBits_q == 4'h0) begin
            if (idx_q < cnt_q) begin
              sum_q <= lspAddc(sum_q, txBuf_q[{idx_q[2:0], 3'b000} +: 8]);
              txSh_q <= {3'b111, txBuf_q[{idx_q[2:0], 3'b000} +: 8], 1'b0};
              // load cycle eats one count, so the gap stays whole bits
              txTmr_q <= bitTime_q - 16'h0002;
              // start, 8 data, stop, then the interbyte gap
              txBits_q <= cfg_q[`LSP_CFG_IBS] ? 4'hc : 4'hb;
              idx_q <= idx_q + 4'h1;
            end else if (idx_q == cnt_q) begin
              txSh_q <= {3'b111, ~sum_q, 1'b0};
              txTmr_q <= bitTime_q - 16'h0002;
              // last count only marks the end of the stop bit
              txBits_q <= 4'hb;
              idx_q <= idx_q + 4'h1;
            end else begin
              txIrq <= 1'b1;
              pid_q <= 8'h00;
              state_q <= S_BRK;
            end
          end
        end
        default: state_q <= S_BRK;
      endcase

      // a break restarts the frame from any state
      if (breakSeen) begin
        txBits_q <= 4'h0;
        linTx <= 1'b1;
        delimArm_q <= 1'b1;
        edges_q <= 3'd0;
        state_q <= cfg_q[`LSP_CFG_HOLD] ? S_SYNC : S_BRK;
      end
      if (raw)
        state_q <= S_BRK;
    end
  end
endmodule
`default_nettype wire

// ==== lsp_regs.vh ====
`ifndef LSP_REGS_VH
`define LSP_REGS_VH
// ==========================================
// clock and timing
`define LSP_CLK_MHZ 50
`define LSP_BIT_NOM_US 52
`define LSP_SYNC_MIN_US 485
`define LSP_SYNC_MAX_US 555
`define LSP_BREAK_MIN_US 572
// cycles at 50 mhz, sized for the 16-bit timers
// sync is timed over its first 8 of 10 bit times
`define LSP_SYNC_MIN_CYC 16'h4bc8
`define LSP_SYNC_MAX_CYC 16'h56b8
`define LSP_BREAK_MIN_CYC 16'h6fb8
// nominal bit less 15 or 30 percent, rounded up
`define LSP_STOP_MIN15_CYC 16'h08a2
`define LSP_STOP_MIN30_CYC 16'h071c
// ==========================================
// register byte offsets
`define LSP_OFS_CFG 8'h00
`define LSP_OFS_CTRL 8'h04
`define LSP_OFS_CNT 8'h08
`define LSP_OFS_STAT 8'h0c
`define LSP_OFS_PID 8'h10
`define LSP_OFS_STATE 8'h14
`define LSP_OFS_RXLO 8'h18
`define LSP_OFS_RXHI 8'h1c
`define LSP_OFS_TXLO 8'h20
`define LSP_OFS_TXHI 8'h24
`define LSP_OFS_BITT 8'h28
// ==========================================
// configuration fields and reset values
`define LSP_CFG_SKIP 0
`define LSP_CFG_HOLD 1
`define LSP_CFG_CSM 2
`define LSP_CFG_IBS 3
`define LSP_CFG_TOL 4
`define LSP_CFG_WIPE 5
`define LSP_CFG_RAW 6
`define LSP_CFG_RST 7'h00
`define LSP_BITT_RST 16'h0a28
`define LSP_CTRL_DIR 0
`define LSP_CNT_MAX 4'h8
// ==========================================
// status fields
`define LSP_ST_CSUM 0
`define LSP_ST_PAR 1
`define LSP_ST_STOPLVL 2
`define LSP_ST_STOPSHORT 3
`define LSP_ST_SYNCSHORT 4
`define LSP_ST_SYNCLONG 5
`define LSP_ST_DELIM 6
`define LSP_RESP_OK 2'b00
`define LSP_RESP_ERR 2'b10
`endif

// ==== lsp_rx_byte.v ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// one-byte receiver, samples at mid-bit
module lsp_rx_byte (
  input wire mclk,
  input wire arst_n,
  input wire enable,
  input wire lineIn,
  input wire [15:0] bitTime,
  output reg done_q,
  output reg [7:0] data_q,
  output reg stopBad_q
);
  reg busy_q;
  reg prev_q;
  reg [15:0] cnt_q;
  reg [3:0] bitIdx_q;
  reg [7:0] sh_q;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      prev_q <= 1'b1;
      cnt_q <= 16'h0000;
      bitIdx_q <= 4'h0;
      sh_q <= 8'h00;
      done_q <= 1'b0;
      data_q <= 8'h00;
      stopBad_q <= 1'b0;
    end else begin
      prev_q <= lineIn;
      done_q <= 1'b0;
      if (!enable) begin
        busy_q <= 1'b0;
      end else if (!busy_q) begin
        if (prev_q && !lineIn) begin
          busy_q <= 1'b1;
          cnt_q <= {1'b0, bitTime[15:1]};
          bitIdx_q <= 4'h0;
        end
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end else begin
        cnt_q <= bitTime - 16'h0001;
        bitIdx_q <= bitIdx_q + 4'h1;
        if (bitIdx_q == 4'h0) begin
          // glitch, not a start bit
          if (lineIn)
            busy_q <= 1'b0;
        end else if (bitIdx_q < 4'h9) begin
          sh_q <= {lineIn, sh_q[7:1]};
        end else begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          data_q <= sh_q;
          stopBad_q <= ~lineIn;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== lsp_top_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module lsp_top_asserts (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic linRx,
  input wire logic linTx,
  input wire logic syncIrq,
  input wire logic idIrq,
  input wire logic rxIrq,
  input wire logic txIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ==========
  // cycles since the bus last fell, saturating
  logic [3:0] fallAge_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) fallAge_q <= 4'hf;
    else if ($fell(linRx)) fallAge_q <= 4'h0;
    else if (fallAge_q != 4'hf) fallAge_q <= fallAge_q + 4'h1;
  end
  sequence wTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence bHeld;
    bvalid && !bready;
  endsequence
  // ==========
  // frame events
  sync_after_fall_a: assert property (syncIrq |-> fallAge_q <= 4'h4)
    else $error("sync irq without a recent bus fall");
  sync_quiet_a: assert property (syncIrq |-> linTx [*8])
    else $error("slave drove the bus while awaiting the identifier");
  id_stop_high_a: assert property (idIrq |-> linRx && $past(linRx, 2))
    else $error("identifier irq without a high stop bit");
  irq_single_a: assert property (idIrq |=> !idIrq && !rxIrq && !txIrq)
    else $error("identifier irq not a lone pulse");
  rx_irq_idle_a: assert property (rxIrq |-> linRx && linTx && !txIrq)
    else $error("receive irq while bus busy");
  tx_irq_end_a: assert property (txIrq |-> linTx && $past(linTx, 8) && !rxIrq)
    else $error("transmit irq before checksum finished");
  // ==========
  // register bus
  write_answer_a: assert property (wTaken |=> !awready && !wready ##1 bvalid)
    else $error("write answer not two cycles after take");
  write_hold_a: assert property (bHeld |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer not one cycle after take");
endmodule
bind lsp_top lsp_top_asserts chk (.mclk(mclk), .arst_n(arst_n), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .linRx(linRx),
  .linTx(linTx), .syncIrq(syncIrq), .idIrq(idIrq), .rxIrq(rxIrq), .txIrq(txIrq));
`default_nettype wire

// ==== lsp_lin_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module lsp_lin_master (
  input wire logic mclk,
  input wire logic busLevel,
  output var logic masterDrv
);
  int bt = 40;
  int cyc = 0;
  initial masterDrv = 1'b1;
  always @(posedge mclk) cyc <= cyc + 1;
  // ==========
  // drive side; callers enter just after a rising edge
  task automatic hold(input logic v, input int n);
    masterDrv <= v;
    repeat (n) @(posedge mclk);
  endtask
  task automatic sendBrk();
    hold(1'b0, 13 * bt);
    hold(1'b1, bt);
  endtask
  task automatic sendByte(input logic [7:0] b);
    hold(1'b0, bt);
    for (int i = 0; i < 8; i++) hold(b[i], bt);
    hold(1'b1, bt);
  endtask
  // ==========
  // listen side, mid-bit sampling; returns at mid stop bit
  task automatic getByte(output logic [7:0] b, output int t);
    while (busLevel) @(posedge mclk);
    t = cyc;
    repeat (bt / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge mclk);
      b[i] = busLevel;
    end
    repeat (bt) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ==== tb_lin_slave_protocol.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lsp_regs.vh"
module tb_lin_slave_protocol;
  localparam logic [63:0] DAT = 64'hf1e2d3c4b5a69788;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, linTx, syncIrq, idIrq, rxIrq, txIrq;
  logic [1:0] bresp, rresp, lastResp;
  logic [7:0] p1, p2;
  int badCount = 0, compares = 0, cyc = 0, nSync = 0, nId = 0, nRx = 0, nTx = 0;
  wire masterDrv;
  wire linRx = linTx & masterDrv;
  always #10 mclk = ~mclk;
  lsp_top #(.SYNC_MIN_CYC(16'h012c), .SYNC_MAX_CYC(16'h015e), .BREAK_MIN_CYC(16'h01b8)) dut (
    .mclk(mclk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .linRx(linRx),
    .linTx(linTx), .syncIrq(syncIrq), .idIrq(idIrq), .rxIrq(rxIrq), .txIrq(txIrq));
  lsp_lin_master M (.mclk(mclk), .busLevel(linRx), .masterDrv(masterDrv));
  always @(posedge mclk) begin
    nSync <= nSync + syncIrq;
    nId <= nId + idIrq;
    nRx <= nRx + rxIrq;
    nTx <= nTx + txIrq;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      badCount++;
      finishTest();
    end
  end
  // ==========
  // helpers
  task automatic finishTest();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      badCount++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // each channel lets go once its own ready was seen
    do begin
      @(posedge mclk);
      if (awready && !awDone) awvalid <= 1'b0;
      if (wready && !wDone) wvalid <= 1'b0;
      awDone = awDone | awready;
      wDone = wDone | wready;
    end while (!(awDone && wDone));
    // late bready keeps the response waiting one cycle
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b1;
    do @(posedge mclk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge mclk); while (!rvalid);
    d = rdata;
    lastResp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(nm, e, v);
  endtask
  function automatic logic [7:0] pidOf(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction
  // carry wraps back into the low byte
  function automatic logic [7:0] csum(input logic [8:0] s, input logic [63:0] d, input int n);
    for (int k = 0; k < n; k++) begin
      s = s[7:0] + d[8*k+:8];
      s = s[7:0] + s[8];
    end
    return ~s[7:0];
  endfunction
  task automatic header(input logic [7:0] p);
    M.sendBrk();
    M.sendByte(8'h55);
    M.sendByte(p);
  endtask
  task automatic rxFrame(input logic [7:0] p, input int n, input logic [7:0] c);
    header(p);
    rc("pid held", `LSP_OFS_PID, {24'h0, p});
    rc("state dir", `LSP_OFS_STATE, 32'h3);
    wr(`LSP_OFS_CNT, 32'(n));
    wr(`LSP_OFS_CTRL, 32'h0);
    for (int k = 0; k < n; k++) M.sendByte(DAT[8*k+:8]);
    M.sendByte(c);
  endtask
  task automatic txFrame(input logic [7:0] p, input int n, input int g, input logic [7:0] c);
    logic [7:0] b;
    int t0, t1;
    header(p);
    wr(`LSP_OFS_TXLO, DAT[31:0]);
    wr(`LSP_OFS_TXHI, DAT[63:32]);
    wr(`LSP_OFS_CNT, 32'(n));
    wr(`LSP_OFS_CTRL, 32'h1);
    for (int k = 0; k <= n; k++) begin
      M.getByte(b, t1);
      chk("tx byte", k < n ? DAT[8*k+:8] : c, b);
      if (k > 0) chk("tx stride", (10 + g) * M.bt, t1 - t0);
      t0 = t1;
    end
    repeat (M.bt + 4) @(posedge mclk);
  endtask
  // ==========
  // main sequence
  initial begin
    p1 = pidOf(6'h11);
    p2 = pidOf(6'h3c);
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rc("cfg reset", `LSP_OFS_CFG, 32'h0);
    rc("bit time reset", `LSP_OFS_BITT, 32'h0a28);
    rd(8'h40, v);
    chk("unmapped resp", 32'h2, {30'h0, lastResp});
    header(p1);
    chk("sync held off", 0, nSync);
    wr(`LSP_OFS_CFG, 32'h42);
    header(p1);
    chk("sync in raw", 0, nSync);
    wr(`LSP_OFS_CFG, 32'h2);
    rxFrame(p1, 8, csum(9'h000, DAT, 8));
    chk("sync irqs", 1, nSync);
    chk("id irqs", 1, nId);
    chk("rx irqs", 1, nRx);
    rc("rx low", `LSP_OFS_RXLO, DAT[31:0]);
    rc("rx high", `LSP_OFS_RXHI, DAT[63:32]);
    rc("pid cleared", `LSP_OFS_PID, 32'h0);
    rc("bit time", `LSP_OFS_BITT, 32'(M.bt));
    rc("status", `LSP_OFS_STAT, 32'h48);
    wr(`LSP_OFS_CFG, 32'h26);
    rc("cfg wipe", `LSP_OFS_CFG, 32'h6);
    rc("status wiped", `LSP_OFS_STAT, 32'h0);
    rxFrame(p2, 3, csum({1'b0, p2}, DAT, 3));
    chk("rx enhanced", 2, nRx);
    rxFrame(p2, 3, csum(9'h000, DAT, 3));
    chk("rx bad sum", 2, nRx);
    rc("status sum", `LSP_OFS_STAT, 32'h49);
    wr(`LSP_OFS_CFG, 32'h22);
    header(p1 ^ 8'h80);
    chk("id on parity", 3, nId);
    rd(`LSP_OFS_STAT, v);
    chk("parity flag", 32'h2, v & 32'h3);
    rc("state parity", `LSP_OFS_STATE, 32'h0);
    wr(`LSP_OFS_CFG, 32'h3);
    header(p1);
    rc("state skip", `LSP_OFS_STATE, 32'h0);
    // idle high run near 2000 cycles: long enough at 30%, short at 15%
    wr(`LSP_OFS_CFG, 32'h33);
    repeat (1950) @(posedge mclk);
    header(p1);
    rd(`LSP_OFS_STAT, v);
    chk("stop tolerance", 32'h40, v & 32'h48);
    wr(`LSP_OFS_CFG, 32'h22);
    txFrame(p1, 4, 1, csum(9'h000, DAT, 4));
    wr(`LSP_OFS_CFG, 32'he);
    txFrame(p2, 2, 2, csum({1'b0, p2}, DAT, 2));
    chk("tx irqs", 2, nTx);
    rc("pid after tx", `LSP_OFS_PID, 32'h0);
    rd(`LSP_OFS_STAT, v);
    chk("stop level", 32'h0, v & 32'h4);
    wr(`LSP_OFS_CFG, 32'h23);
    M.bt = 36;
    header(p1);
    rd(`LSP_OFS_STAT, v);
    chk("sync short", 32'h10, v & 32'h30);
    wr(`LSP_OFS_CFG, 32'h23);
    M.bt = 45;
    header(p1);
    rd(`LSP_OFS_STAT, v);
    chk("sync long", 32'h20, v & 32'h30);
    finishTest();
  end
endmodule
`default_nettype wire
